// File: csp_pkg.sv
// Shared constants, types and helpers for the CPU state and pointer register block
package csp_pkg;

   // Special function register addresses
   localparam logic [7:0] SFR_STACK_PTR   = 8'h81;
   localparam logic [7:0] SFR_DATA_POINTER_LOW    = 8'h82;
   localparam logic [7:0] SFR_DATA_POINTER_HIGH   = 8'h83;
   localparam logic [7:0] SFR_AUX_CTRL    = 8'hA2;
   localparam logic [7:0] SFR_STATUS_WORD = 8'hD0;

   // Values after reset
   localparam logic [7:0]  STACK_PTR_RESET   = 8'h07;
   localparam logic [7:0]  STATUS_WORD_RESET = 8'h00;
   localparam logic [7:0]  AUX_CTRL_RESET    = 8'h00;
   localparam logic [15:0] DATA_POINTER_RESET        = 16'h0000;

   // Status word field positions
   localparam int PSW_CARRY      = 7;
   localparam int PSW_HALF_CARRY = 6;
   localparam int PSW_USER_ZERO  = 5;
   localparam int PSW_BANK_HIGH  = 4;
   localparam int PSW_BANK_LOW   = 3;
   localparam int PSW_OVERFLOW   = 2;
   localparam int PSW_USER_ONE   = 1;
   localparam int PSW_PARITY     = 0;

   // Auxiliary control field positions; bits 7 and 1 are reserved
   localparam int AUX_CA_REDIRECT   = 6;
   localparam int AUX_SPI_REDIRECT  = 5;
   localparam int AUX_SECOND_UART_REDIRECT = 4;
   localparam int AUX_GENERAL_FLAG  = 3;
   localparam int AUX_JUSTIFY       = 2;
   localparam int AUX_PTR_SELECT    = 0;
   localparam logic [7:0] AUX_WRITE_MASK = 8'h7D;

   // Internal RAM and SFR space split for direct addressing
   localparam logic [7:0] SFR_SPACE_BASE = 8'h80;

   // Port function masks for each pin placement
   localparam logic [7:0] CA_PORT1_MASK    = 8'h1C;
   localparam logic [3:0] CA_PORT4_MASK    = 4'hE;
   localparam logic [7:0] SPI_PORT1_MASK   = 8'hF0;
   localparam logic [3:0] SPI_PORT4_MASK   = 4'hF;
   localparam logic [7:0] SECOND_UART_PORT1_MASK = 8'h0C;
   localparam logic [3:0] SECOND_UART_PORT4_MASK = 4'hC;

   typedef enum logic [3:0] {
      MODE_NONE, MODE_REG, MODE_DIR, MODE_IND_RI, MODE_IND_SP, MODE_IND_DATA_POINTER,
      MODE_IMM, MODE_IDX_DATA_POINTER, MODE_IDX_PC, MODE_JMP_IDX
   } csp_mode_type;

   typedef enum logic [1:0] {SPACE_IRAM, SPACE_SFR, SPACE_XRAM, SPACE_CODE} csp_space_type;

   typedef struct packed {
      csp_space_type space;
      logic [15:0]   addr;
   } csp_operand_type;

   typedef struct packed {
      logic carry;
      logic half_carry;
      logic overflow;
   } csp_flags_type;

   typedef struct packed {
      logic [7:0] ca_p1;
      logic [3:0] ca_p4;
      logic [7:0] spi_p1;
      logic [3:0] serial_periph_redirect;
      logic [7:0] second_uart_p1;
      logic [3:0] second_uart_p4;
   } csp_route_type;

   // Base plus accumulator, wrapping in 16 bits
   function automatic logic [15:0] csp_add_index(input logic [15:0] base, input logic [7:0] acc);
      csp_add_index = base + {8'h00, acc};
   endfunction : csp_add_index

endpackage : csp_pkg

// File: csp_addr_resolve.sv
// Operand address resolution for the core addressing modes
`timescale 1ns/1ps
module csp_addr_resolve
   import csp_pkg::*;
(
   input  wire csp_mode_type    mode_in,
   input  wire logic [7:0]      opcode_in,
   input  wire logic [7:0]      direct_in,
   input  wire logic [7:0]      ri_value_in,
   input  wire logic [1:0]      bank_in,
   input  wire logic [7:0]      sp_in,
   input  wire logic [15:0]     data_pointer_in,
   input  wire logic [15:0]     pc_in,
   input  wire logic [7:0]      acc_in,
   output csp_operand_type      operand_out,
   output logic [15:0]          jump_target_out
);

   // Mode decode to operand space and address
   always_comb begin
      operand_out     = '{space: SPACE_IRAM, addr: 16'h0000};
      jump_target_out = csp_add_index(data_pointer_in, acc_in);
      unique case (mode_in)
         MODE_NONE: operand_out = '{space: SPACE_IRAM, addr: 16'h0000};
         MODE_REG: operand_out = '{space: SPACE_IRAM, addr: {11'h000, bank_in, opcode_in[2:0]}};
         MODE_DIR: begin
            operand_out.addr  = {8'h00, direct_in};
            operand_out.space = (direct_in < SFR_SPACE_BASE) ? SPACE_IRAM : SPACE_SFR;
         end
         MODE_IND_RI: operand_out = '{space: SPACE_IRAM, addr: {8'h00, ri_value_in}};
         MODE_IND_SP: operand_out = '{space: SPACE_IRAM, addr: {8'h00, sp_in}};
         MODE_IND_DATA_POINTER: operand_out = '{space: SPACE_XRAM, addr: data_pointer_in};
         MODE_IMM: operand_out = '{space: SPACE_CODE, addr: pc_in + 16'h0001};
         MODE_IDX_DATA_POINTER: operand_out = '{space: SPACE_CODE, addr: csp_add_index(data_pointer_in, acc_in)};
         MODE_IDX_PC: operand_out = '{space: SPACE_CODE, addr: csp_add_index(pc_in, acc_in)};
         MODE_JMP_IDX: operand_out = '{space: SPACE_CODE, addr: csp_add_index(data_pointer_in, acc_in)};
         default: operand_out = '{space: SPACE_IRAM, addr: 16'h0000};
      endcase
   end

endmodule : csp_addr_resolve

// File: csp_pin_route.sv
// Pin redirection masks and conversion result arrangement
`timescale 1ns/1ps
module csp_pin_route
   import csp_pkg::*;
(
   input  wire logic [7:0] aux_in,
   input  wire logic [9:0] conv_raw_in,
   output csp_route_type   route_out,
   output logic [7:0]      conv_high_out,
   output logic [7:0]      conv_low_out
);

   // Each peripheral sits on port 1 by default and on port 4 when redirected
   always_comb begin
      route_out.ca_p1    = aux_in[AUX_CA_REDIRECT] ? 8'h00 : CA_PORT1_MASK;
      route_out.ca_p4    = aux_in[AUX_CA_REDIRECT] ? CA_PORT4_MASK : 4'h0;
      route_out.spi_p1   = aux_in[AUX_SPI_REDIRECT] ? 8'h00 : SPI_PORT1_MASK;
      route_out.serial_periph_redirect   = aux_in[AUX_SPI_REDIRECT] ? SPI_PORT4_MASK : 4'h0;
      route_out.second_uart_p1 = aux_in[AUX_SECOND_UART_REDIRECT] ? 8'h00 : SECOND_UART_PORT1_MASK;
      route_out.second_uart_p4 = aux_in[AUX_SECOND_UART_REDIRECT] ? SECOND_UART_PORT4_MASK : 4'h0;
   end

   // Left or right justified placement of the 10-bit result
   always_comb begin
      if (aux_in[AUX_JUSTIFY]) begin
         conv_high_out = {6'h00, conv_raw_in[9:8]};
         conv_low_out  = conv_raw_in[7:0];
      end else begin
         conv_high_out = conv_raw_in[9:2];
         conv_low_out  = {6'h00, conv_raw_in[1:0]};
      end
   end

endmodule : csp_pin_route

// File: csp_regs.sv
// CPU state and pointer registers: stack pointer, status word, dual data pointer, aux control
`timescale 1ns/1ps
module csp_regs
   import csp_pkg::*;
(
   input  wire logic            mclk_in,
   input  wire logic            resetn_in,
   input  wire logic [7:0]      sfr_addr_in,
   input  wire logic            sfr_wr_in,
   input  wire logic            sfr_rd_in,
   input  wire logic [7:0]      sfr_wdata_in,
   output logic [7:0]           sfr_rdata_out,
   output logic                 sfr_hit_out,
   input  wire logic [7:0]      acc_in,
   input  wire logic            flag_wr_in,
   input  wire csp_flags_type   flags_in,
   input  wire logic            bit_carry_wr_in,
   input  wire logic            bit_carry_in,
   input  wire logic            stack_push_in,
   input  wire logic            stack_pop_in,
   input  wire logic            data_pointer_load_in,
   input  wire logic [15:0]     data_pointer_value_in,
   input  wire logic            data_pointer_inc_in,
   input  wire csp_mode_type    mode_in,
   input  wire logic [7:0]      opcode_in,
   input  wire logic [7:0]      direct_in,
   input  wire logic [7:0]      ri_value_in,
   input  wire logic [15:0]     pc_in,
   input  wire logic [9:0]      conv_raw_in,
   output logic [7:0]           stack_pointer_out,
   output logic [7:0]           program_status_word_out,
   output logic [15:0]          data_pointer_out,
   output logic [7:0]           aux_pin_and_pointer_ctrl_out,
   output csp_operand_type      operand_out,
   output logic [15:0]          jump_target_out,
   output csp_route_type        route_out,
   output logic [7:0]           conversion_result_high_out,
   output logic [7:0]           conversion_result_low_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Reset release and local state

   logic                  rst_sync_a;
   logic                  rst_n;
   logic [7:0]            stack_pointer;
   logic [7:0]            program_status_word;
   logic [15:0]           data_pointer_active;
   logic [15:0]           data_pointer_shadow;
   logic [7:0]            aux_ctrl;
   logic                  wr_sp;
   logic                  wr_psw;
   logic                  wr_dpl;
   logic                  wr_dph;
   logic                  wr_aux;
   logic [7:0]            next_aux;
   logic                  sel_swap;
   csp_operand_type       next_operand;
   logic [15:0]           next_jump_target;
   csp_route_type         next_route;
   logic [7:0]            next_conv_high;
   logic [7:0]            next_conv_low;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_a <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_sync_a <= 1'b1;
         rst_n      <= rst_sync_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register write decode

   // Software writes win over hardware updates of the same register
   always_comb begin
      wr_sp    = sfr_wr_in && (sfr_addr_in == SFR_STACK_PTR);
      wr_psw   = sfr_wr_in && (sfr_addr_in == SFR_STATUS_WORD);
      wr_dpl   = sfr_wr_in && (sfr_addr_in == SFR_DATA_POINTER_LOW);
      wr_dph   = sfr_wr_in && (sfr_addr_in == SFR_DATA_POINTER_HIGH);
      wr_aux   = sfr_wr_in && (sfr_addr_in == SFR_AUX_CTRL);
      next_aux = sfr_wdata_in & AUX_WRITE_MASK;
      sel_swap = wr_aux && (next_aux[AUX_PTR_SELECT] != aux_ctrl[AUX_PTR_SELECT]);
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Stack pointer

   // Pre-increment on push or call, decrement on pop or return
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         stack_pointer <= STACK_PTR_RESET;
      end else if (wr_sp) begin
         stack_pointer <= sfr_wdata_in;
      end else if (stack_push_in && !stack_pop_in) begin
         stack_pointer <= stack_pointer + 8'h01;
      end else if (stack_pop_in && !stack_push_in) begin
         stack_pointer <= stack_pointer - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Program status word

   // Arithmetic flags, Boolean carry and software writes; parity is read only
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         program_status_word <= STATUS_WORD_RESET;
      end else begin
         if (wr_psw) begin
            program_status_word[7:1] <= sfr_wdata_in[7:1];
         end else begin
            if (flag_wr_in) begin
               program_status_word[PSW_CARRY]      <= flags_in.carry;
               program_status_word[PSW_HALF_CARRY] <= flags_in.half_carry;
               program_status_word[PSW_OVERFLOW]   <= flags_in.overflow;
            end
            if (bit_carry_wr_in) begin
               program_status_word[PSW_CARRY] <= bit_carry_in;
            end
         end
         program_status_word[PSW_PARITY] <= ^acc_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Dual data pointer

   // The selected pointer always lives in the active copy; a selector change swaps the copies
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         data_pointer_active <= DATA_POINTER_RESET;
         data_pointer_shadow <= DATA_POINTER_RESET;
      end else if (sel_swap) begin
         data_pointer_active <= data_pointer_shadow;
         data_pointer_shadow <= data_pointer_active;
      end else if (wr_dpl || wr_dph) begin
         if (wr_dpl) begin
            data_pointer_active[7:0] <= sfr_wdata_in;
         end
         if (wr_dph) begin
            data_pointer_active[15:8] <= sfr_wdata_in;
         end
      end else if (data_pointer_load_in) begin
         data_pointer_active <= data_pointer_value_in;
      end else if (data_pointer_inc_in) begin
         data_pointer_active <= data_pointer_active + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Auxiliary control register

   // Reserved bits never store, so an increment from zero only flips the selector
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         aux_ctrl <= AUX_CTRL_RESET;
      end else if (wr_aux) begin
         aux_ctrl <= next_aux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register read port

   // Read data registered one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata_out <= 8'h00;
         sfr_hit_out   <= 1'b0;
      end else if (sfr_rd_in) begin
         sfr_hit_out <= 1'b1;
         unique case (sfr_addr_in)
            SFR_STACK_PTR:   sfr_rdata_out <= stack_pointer;
            SFR_STATUS_WORD: sfr_rdata_out <= program_status_word;
            SFR_DATA_POINTER_LOW:    sfr_rdata_out <= data_pointer_active[7:0];
            SFR_DATA_POINTER_HIGH:   sfr_rdata_out <= data_pointer_active[15:8];
            SFR_AUX_CTRL:    sfr_rdata_out <= aux_ctrl;
            default: begin
               sfr_rdata_out <= 8'h00;
               sfr_hit_out   <= 1'b0;
            end
         endcase
      end else begin
         sfr_hit_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Address resolution and pin routing

   csp_addr_resolve u_resolve (
      .mode_in         (mode_in),
      .opcode_in       (opcode_in),
      .direct_in       (direct_in),
      .ri_value_in     (ri_value_in),
      .bank_in         (program_status_word[PSW_BANK_HIGH:PSW_BANK_LOW]),
      .sp_in           (stack_pointer),
      .data_pointer_in         (data_pointer_active),
      .pc_in           (pc_in),
      .acc_in          (acc_in),
      .operand_out     (next_operand),
      .jump_target_out (next_jump_target)
   );

   csp_pin_route u_route (
      .aux_in        (aux_ctrl),
      .conv_raw_in   (conv_raw_in),
      .route_out     (next_route),
      .conv_high_out (next_conv_high),
      .conv_low_out  (next_conv_low)
   );

   // Registered copies of the resolver and routing results
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         operand_out                <= '{space: SPACE_IRAM, addr: 16'h0000};
         jump_target_out            <= 16'h0000;
         route_out                  <= '0;
         conversion_result_high_out <= 8'h00;
         conversion_result_low_out  <= 8'h00;
      end else begin
         operand_out                <= next_operand;
         jump_target_out            <= next_jump_target;
         route_out                  <= next_route;
         conversion_result_high_out <= next_conv_high;
         conversion_result_low_out  <= next_conv_low;
      end
   end

   // Architectural state straight from its flops
   always_comb begin
      stack_pointer_out            = stack_pointer;
      program_status_word_out      = program_status_word;
      data_pointer_out             = data_pointer_active;
      aux_pin_and_pointer_ctrl_out = aux_ctrl;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   stack_push_inc_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      stack_push_in && !stack_pop_in && !wr_sp |=> stack_pointer == $past(stack_pointer) + 8'h01)
      else $error("stack pointer did not pre-increment on push");

   stack_reset_a: assert property (@(posedge mclk_in)
      $rose(rst_n) |-> stack_pointer == 8'h07)
      else $error("stack pointer not 07H after reset");

   parity_track_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      ##1 program_status_word[PSW_PARITY] == ^$past(acc_in))
      else $error("parity bit does not follow accumulator");

   bool_carry_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      bit_carry_wr_in && !wr_psw |=> program_status_word[PSW_CARRY] == $past(bit_carry_in))
      else $error("carry not written by bit instruction");

   data_pointer_byte_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      wr_dpl && !wr_dph && !sel_swap |=> data_pointer_active[15:8] == $past(data_pointer_active[15:8])
         && data_pointer_active[7:0] == $past(sfr_wdata_in))
      else $error("low byte write disturbed high byte");

   ptr_swap_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      sel_swap |=> data_pointer_active == $past(data_pointer_shadow) && data_pointer_shadow == $past(data_pointer_active))
      else $error("selector change did not swap pointers");

   ptr_other_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      !sel_swap |=> data_pointer_shadow == $past(data_pointer_shadow))
      else $error("unselected pointer changed");

   sel_toggle_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      wr_aux && sfr_wdata_in == aux_ctrl + 8'h01 && (aux_ctrl & 8'hFE) == 8'h00
      |=> aux_ctrl[AUX_PTR_SELECT] != $past(aux_ctrl[AUX_PTR_SELECT]))
      else $error("aux increment did not toggle selector");

   reg_bank_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      mode_in == MODE_REG |=> operand_out.addr == {11'h000, $past(program_status_word[4:3]),
         $past(opcode_in[2:0])})
      else $error("register operand outside selected bank");

   direct_space_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      mode_in == MODE_DIR |=> operand_out.space == ($past(direct_in[7]) ? SPACE_SFR : SPACE_IRAM))
      else $error("direct operand space wrong");

   justify_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
      aux_ctrl[AUX_JUSTIFY] |=> conversion_result_low_out == $past(conv_raw_in[7:0]))
      else $error("right justified low byte wrong");

endmodule : csp_regs

// File: csp_core_model.sv
// Behavioural model of the core datapath accumulator that feeds the register block
`timescale 1ns/1ps
module csp_core_model (
   input  wire logic       mclk_in,
   input  wire logic       acc_load_in,
   input  wire logic [7:0] acc_value_in,
   output logic [7:0]      acc_out
);
   // Accumulator starts cleared so parity never sees an unknown
   initial acc_out = 8'h00;
   // Datapath loads the accumulator on the clock edge
   always @(posedge mclk_in) begin
      if (acc_load_in) acc_out <= acc_value_in;
   end
endmodule : csp_core_model

// File: tb_top.sv
// Self-checking testbench of the CPU state and pointer register block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("Error at %0t ns: got %h expected %h", $time, g, e); end end
module tb_top
   import csp_pkg::*;
;
   logic            mclk_in = 1'b0, resetn_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, acc_load = 1'b0;
   logic            flag_wr_in = 1'b0, bit_carry_wr_in = 1'b0, bit_carry_in = 1'b0, stack_push_in = 1'b0;
   logic            stack_pop_in = 1'b0, data_pointer_load_in = 1'b0, data_pointer_inc_in = 1'b0, sfr_hit_out;
   logic [7:0]      sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, opcode_in = 8'h00, direct_in = 8'h00;
   logic [7:0]      ri_value_in = 8'h00, acc_value = 8'h00, acc_in, r8, sfr_rdata_out, stack_pointer_out;
   logic [7:0]      program_status_word_out, aux_pin_and_pointer_ctrl_out;
   logic [7:0]      conversion_result_high_out, conversion_result_low_out;
   logic [15:0]     data_pointer_value_in = 16'h0000, pc_in = 16'h0000, data_pointer_out, jump_target_out;
   logic [9:0]      conv_raw_in = 10'h000;
   logic [31:0]     seed = 32'h0000_0012;
   csp_flags_type   flags_in = 3'h0;
   csp_mode_type    mode_in = MODE_NONE;
   csp_operand_type operand_out, exp_o;
   logic [15:0]     exp_c;
   csp_route_type   route_out;
   int              bad_count = 0, compares = 0;

   csp_core_model i_core (.mclk_in, .acc_load_in(acc_load), .acc_value_in(acc_value), .acc_out(acc_in));
   csp_regs i_dut (.mclk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
      .sfr_hit_out, .acc_in, .flag_wr_in, .flags_in, .bit_carry_wr_in, .bit_carry_in, .stack_push_in,
      .stack_pop_in, .data_pointer_load_in, .data_pointer_value_in, .data_pointer_inc_in, .mode_in, .opcode_in, .direct_in,
      .ri_value_in, .pc_in, .conv_raw_in, .stack_pointer_out, .program_status_word_out, .data_pointer_out,
      .aux_pin_and_pointer_ctrl_out, .operand_out, .jump_target_out, .route_out,
      .conversion_result_high_out, .conversion_result_low_out);

   // Clock and hang guard
   initial forever #20 mclk_in = ~mclk_in;
   initial begin
      repeat (20000) @(posedge mclk_in);
      bad_count++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////
   // Random source and expectation helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic csp_operand_type exp_op(csp_mode_type m);
      csp_operand_type o;
      o = '{SPACE_CODE, data_pointer_out + {8'h00, acc_in}};
      case (m)
         MODE_REG:      o = '{SPACE_IRAM, {11'h000, program_status_word_out[4:3], opcode_in[2:0]}};
         MODE_DIR:      o = '{(direct_in < 8'h80) ? SPACE_IRAM : SPACE_SFR, {8'h00, direct_in}};
         MODE_IND_RI:   o = '{SPACE_IRAM, {8'h00, ri_value_in}};
         MODE_IND_SP:   o = '{SPACE_IRAM, {8'h00, stack_pointer_out}};
         MODE_IND_DATA_POINTER: o = '{SPACE_XRAM, data_pointer_out};
         MODE_IMM:      o = '{SPACE_CODE, pc_in + 16'h0001};
         MODE_IDX_PC:   o = '{SPACE_CODE, pc_in + {8'h00, acc_in}};
         default: ;
      endcase
      return o;
   endfunction : exp_op
   function automatic csp_route_type exp_route(logic [7:0] a);
      return '{a[6] ? 8'h00 : 8'h1C, a[6] ? 4'hE : 4'h0, a[5] ? 8'h00 : 8'hF0, a[5] ? 4'hF : 4'h0,
               a[4] ? 8'h00 : 8'h0C, a[4] ? 4'hC : 4'h0};
   endfunction : exp_route
   ////////////////////////////////////////////////////////////
   // Bus cycles and strobes; each ends just after the answering edge, set_acc one edge later
   task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= wr;
      sfr_rd_in <= ~wr;
      @(posedge mclk_in);
      sfr_wr_in <= 1'b0;
      sfr_rd_in <= 1'b0;
      #1;
   endtask : sfr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      sfr(1'b0, a, 8'h00);
      `CHK({sfr_hit_out, sfr_rdata_out}, {h, e})
   endtask : rd
   task automatic fire(input logic [5:0] s);
      @(posedge mclk_in);
      {flag_wr_in, bit_carry_wr_in, stack_push_in, stack_pop_in, data_pointer_load_in, data_pointer_inc_in} <= s;
      @(posedge mclk_in);
      {flag_wr_in, bit_carry_wr_in, stack_push_in, stack_pop_in, data_pointer_load_in, data_pointer_inc_in} <= 6'h00;
      #1;
   endtask : fire
   task automatic set_acc(input logic [7:0] v);
      @(posedge mclk_in);
      acc_value <= v;
      acc_load <= 1'b1;
      @(posedge mclk_in);
      acc_load <= 1'b0;
      @(posedge mclk_in);
      #1;
   endtask : set_acc
   task automatic stop_test();
      if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      #1;
      `CHK({stack_pointer_out, program_status_word_out, aux_pin_and_pointer_ctrl_out}, 24'h070000)
      fire(6'h08);
      rd(SFR_STACK_PTR, 8'h08, 1'b1);
      sfr(1'b1, SFR_STACK_PTR, 8'hFF);
      fire(6'h08);
      `CHK(stack_pointer_out, 8'h00)
      fire(6'h04);
      `CHK(stack_pointer_out, 8'hFF)
      fire(6'h0C);
      `CHK(stack_pointer_out, 8'hFF)
      rd(8'h80, 8'h00, 1'b0);
      for (int i = 0; i < 6; i++) begin
         r8 = 8'(xs());
         set_acc(8'(xs()));
         sfr(1'b1, SFR_STATUS_WORD, r8);
         rd(SFR_STATUS_WORD, {r8[7:1], ^acc_in}, 1'b1);
      end
      sfr(1'b1, SFR_STATUS_WORD, 8'h00);
      flags_in <= 3'b101;
      fire(6'h20);
      `CHK(program_status_word_out[7:1], 7'b1000010)
      flags_in <= 3'b111;
      fire(6'h30);
      `CHK(program_status_word_out[7:1], 7'b0100010)
      data_pointer_value_in <= 16'h01FF;
      fire(6'h02);
      sfr(1'b1, SFR_AUX_CTRL, 8'h01);
      `CHK(data_pointer_out, 16'h0000)
      data_pointer_value_in <= 16'h02FF;
      fire(6'h02);
      sfr(1'b1, SFR_DATA_POINTER_LOW, 8'h34);
      sfr(1'b1, SFR_AUX_CTRL, 8'h00);
      `CHK(data_pointer_out, 16'h01FF)
      fire(6'h01);
      `CHK(data_pointer_out, 16'h0200)
      sfr(1'b1, SFR_AUX_CTRL, 8'h01);
      sfr(1'b1, SFR_DATA_POINTER_HIGH, 8'hA5);
      rd(SFR_DATA_POINTER_LOW, 8'h34, 1'b1);
      `CHK(data_pointer_out, 16'hA534)
      for (int b = 0; b < 4; b++) begin
         set_acc(8'(xs()));
         data_pointer_value_in <= 16'(xs());
         fire(6'h02);
         sfr(1'b1, SFR_STATUS_WORD, {3'b000, 2'(b), 3'b000});
         for (int m = 1; m < 10; m++) begin
            @(posedge mclk_in);
            mode_in <= csp_mode_type'(m);
            {opcode_in, direct_in, ri_value_in} <= 24'(xs());
            pc_in <= 16'(xs());
            #1;
            exp_o = exp_op(mode_in);
            @(posedge mclk_in);
            #1;
            `CHK(operand_out, exp_o)
            `CHK(jump_target_out, data_pointer_out + {8'h00, acc_in})
         end
      end
      for (int i = 0; i < 12; i++) begin
         r8 = 8'(xs());
         conv_raw_in <= 10'(xs());
         sfr(1'b1, SFR_AUX_CTRL, r8);
         rd(SFR_AUX_CTRL, r8 & 8'h7D, 1'b1);
         `CHK(route_out, exp_route(r8))
         exp_c = r8[2] ? {6'h00, conv_raw_in} : {conv_raw_in[9:2], 6'h00, conv_raw_in[1:0]};
         `CHK({conversion_result_high_out, conversion_result_low_out}, exp_c)
      end
      stop_test();
   end
endmodule : tb_top
